// ### design/vpc_pin_control.sv
// Mode steering of blanking, dot clock choice, sync and mux flag pins.
// Assumes host strobes and all pins synchronous to the 20 MHz clk_in.
// Summary of operation
// R1: Blanking comes from alternate input in pass-through, else normal input.
// R2: Pass-through selects dot clock input zero by default.
// R3: TTL clock accepted on either dual-mode leg when selection says so.
// R4: Normal modes: active-low syncs through a true/complement gate.
// R5: Pass-through forwards syncs without inversion regardless of polarity.
// R6: Sync inputs insert the sync level into green current output.
// R7: Mux flag goes low when mux control is written with the pass-through code, until R8 raises it.
// R8: Top general control bit set after code drives mux flag high.
// R9: Mux flag feeds nothing inside; it only signals outside.
// R10: Pixel port interpreted per mux mode, little or big endian; the code swaps bytes on big_endian_in alone, whatever the mux mode.
// R11: Eight-bit bidirectional host bus carries register and memory data.
// R12: Host read strobe low starts a read on its falling edge.
// R13: Host gives four-bit register select each access.
// R14: Pass-through decode applies blank, clock, sync choices in one update.
`timescale 1ns/1ns
`default_nettype none
module vpc_pin_control
    import vpc_pkg::*;
#(
    parameter int PIX_W = PIX_WIDTH
)
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] mux_ctrl_in,
    input wire logic mux_ctrl_we_in,
    input wire logic [7:0] gen_ctrl_in,
    input wire logic gen_ctrl_we_in,
    input wire logic [3:0] clk_sel_in,
    input wire logic hsync_invert_in,
    input wire logic vsync_invert_in,
    input wire logic big_endian_in,
    input wire logic blank_n_in,
    input wire logic alt_blank_in,
    input wire logic hsync_n_in,
    input wire logic vsync_n_in,
    input wire logic [PIX_W-1:0] pixel_in,
    input wire logic read_n_in,
    input wire logic write_n_in,
    input wire logic [3:0] reg_select,
    input wire logic [7:0] host_data_in,
    input wire logic [7:0] read_data_in,
    output logic [7:0] host_data_out,
    output logic host_data_oe_n_out,
    output logic [3:0] host_reg_sel_out,
    output logic host_read_pulse_out,
    output logic host_write_pulse_out,
    output logic [7:0] host_write_data_out,
    output logic blank_n_out,
    output logic [1:0] clk_source_out,
    output logic dual_ttl_comp_out,
    output logic dual_ttl_en_out,
    output logic hsync_output_pin,
    output logic vsync_output_pin,
    output logic green_sync_n_out,
    output logic external_mux_flag,
    output logic passthru_out,
    output logic [PIX_W-1:0] pixel_out
);
    logic rst_meta;
    logic rst_n;
    logic [7:0] mux_reg;
    logic [7:0] next_mux_reg;
    logic mux_flag_armed;
    logic next_mux_flag_armed;
    logic next_mux_flag;
    logic pass_dec;
    logic next_blank_n;
    logic [1:0] next_clk_source;
    logic next_dual_ttl_en;
    logic next_dual_ttl_comp;
    logic next_passthru;
    logic next_green_sync_n;
    logic [PIX_W-1:0] next_pixel;
    vpc_host_e host_state;
    vpc_host_e next_host_state;
    logic read_n_d;
    logic write_n_d;
    logic [7:0] next_host_data;
    logic next_host_oe_n;
    logic [3:0] next_reg_sel;
    logic next_read_pulse;
    logic next_write_pulse;
    logic [7:0] next_write_data;

    // Reset release through two flops; assert is async
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    function automatic logic [PIX_W-1:0] byte_swap(input logic [PIX_W-1:0] d);
        logic [PIX_W-1:0] r;
        r = '0;
        for (int i = 0; i < PIX_W / 8; i++)
        begin
            r[i*8 +: 8] = d[(PIX_W/8 - 1 - i)*8 +: 8];
        end
        byte_swap = r;
    endfunction

    // Mode register and mux flag state
    always_comb
    begin
        next_mux_reg = mux_reg;
        next_mux_flag_armed = mux_flag_armed;
        if (mux_ctrl_we_in)
        begin
            next_mux_reg = mux_ctrl_in;
            // New code drops the flag; bit 7 must be rewritten after
            next_mux_flag_armed = 1'b0; // R7
        end
        else if (gen_ctrl_we_in && is_passthru(mux_reg))
        begin
            next_mux_flag_armed = gen_ctrl_in[GCTL_MUXFLAG_BIT]; // R8
        end
        // Outside pass-through the flag reads high
        next_mux_flag = !is_passthru(next_mux_reg) || next_mux_flag_armed;
    end

    // One decode drives every mode-dependent choice together except the mux flag, decoded from the next code
    always_comb
    begin
        pass_dec = is_passthru(mux_reg); // R14
        next_passthru = pass_dec;
        next_blank_n = pass_dec ? alt_blank_in : blank_n_in; // R1
        next_dual_ttl_en = 1'b0;
        next_dual_ttl_comp = 1'b0;
        if (pass_dec)
        begin
            next_clk_source = CLKSRC_ZERO; // R2
        end
        else if (clk_sel_in == CLKSEL_DUAL_TRUE_TTL)
        begin
            next_clk_source = CLKSRC_DUAL; // R3
            next_dual_ttl_en = 1'b1;
        end
        else if (clk_sel_in == CLKSEL_DUAL_COMP_TTL)
        begin
            next_clk_source = CLKSRC_DUAL; // R3
            next_dual_ttl_en = 1'b1;
            next_dual_ttl_comp = 1'b1;
        end
        else
        begin
            next_clk_source = clk_sel_in[1:0];
        end
        // Either sync low forces the green sync level
        next_green_sync_n = hsync_n_in & vsync_n_in; // R6
        next_pixel = big_endian_in ? byte_swap(pixel_in) : pixel_in; // R10
    end

    // Host strobe capture; read begins on strobe falling edge
    always_comb
    begin
        next_host_state = host_state;
        next_read_pulse = 1'b0;
        next_write_pulse = 1'b0;
        next_reg_sel = host_reg_sel_out;
        next_host_data = host_data_out;
        next_host_oe_n = 1'b1;
        next_write_data = host_write_data_out;
        case (host_state)
            VPC_HOST_IDLE:
            begin
                if (read_n_d && !read_n_in)
                begin
                    next_host_state = VPC_HOST_READ; // R12
                    next_read_pulse = 1'b1;
                    next_reg_sel = reg_select; // R13
                end
                else if (write_n_d && !write_n_in)
                begin
                    next_host_state = VPC_HOST_WRITE;
                    next_reg_sel = reg_select; // R13
                end
            end
            VPC_HOST_READ:
            begin
                next_host_data = read_data_in; // R11
                next_host_oe_n = read_n_in;
                if (read_n_in)
                begin
                    next_host_state = VPC_HOST_IDLE;
                    next_host_data = READ_IDLE;
                end
            end
            VPC_HOST_WRITE:
            begin
                if (write_n_in)
                begin
                    // Data latched on rising strobe, as hosts hold it then
                    next_write_data = host_data_in; // R11
                    next_write_pulse = 1'b1;
                    next_host_state = VPC_HOST_IDLE;
                end
            end
            default:
            begin
                next_host_state = VPC_HOST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mux_reg <= MUX_RESET;
            mux_flag_armed <= 1'b0;
            external_mux_flag <= 1'b1;
            passthru_out <= 1'b0;
            blank_n_out <= 1'b0;
            clk_source_out <= CLKSRC_ZERO;
            dual_ttl_en_out <= 1'b0;
            dual_ttl_comp_out <= 1'b0;
            green_sync_n_out <= 1'b1;
            pixel_out <= '0;
            host_state <= VPC_HOST_IDLE;
            read_n_d <= 1'b1;
            write_n_d <= 1'b1;
            host_data_out <= READ_IDLE;
            host_data_oe_n_out <= 1'b1;
            host_reg_sel_out <= 4'h0;
            host_read_pulse_out <= 1'b0;
            host_write_pulse_out <= 1'b0;
            host_write_data_out <= 8'h00;
        end
        else
        begin
            mux_reg <= next_mux_reg;
            mux_flag_armed <= next_mux_flag_armed;
            // Output only; nothing inside reads it
            external_mux_flag <= next_mux_flag; // R9
            passthru_out <= next_passthru;
            blank_n_out <= next_blank_n;
            clk_source_out <= next_clk_source;
            dual_ttl_en_out <= next_dual_ttl_en;
            dual_ttl_comp_out <= next_dual_ttl_comp;
            green_sync_n_out <= next_green_sync_n;
            pixel_out <= next_pixel;
            host_state <= next_host_state;
            read_n_d <= read_n_in;
            write_n_d <= write_n_in;
            host_data_out <= next_host_data;
            host_data_oe_n_out <= next_host_oe_n;
            host_reg_sel_out <= next_reg_sel;
            host_read_pulse_out <= next_read_pulse;
            host_write_pulse_out <= next_write_pulse;
            host_write_data_out <= next_write_data;
        end
    end

    vpc_sync_gate u_hsync_gate (
        .clk_in(clk_in),
        .rst_n(rst_n),
        .sync_n_in(hsync_n_in),
        .invert_in(hsync_invert_in),
        .passthru_in(pass_dec),
        .sync_out(hsync_output_pin)
    );

    vpc_sync_gate u_vsync_gate (
        .clk_in(clk_in),
        .rst_n(rst_n),
        .sync_n_in(vsync_n_in),
        .invert_in(vsync_invert_in),
        .passthru_in(pass_dec),
        .sync_out(vsync_output_pin)
    );

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n);

    // First cycle after reset still shows reset values
    a_blank_select: assert property ($past(rst_n) |-> // R1
        ($past(pass_dec) ? blank_n_out == $past(alt_blank_in)
        : blank_n_out == $past(blank_n_in)))
        else $error("blank source wrong");
    a_clk_zero: assert property ( // R2
        passthru_out |-> clk_source_out == CLKSRC_ZERO)
        else $error("clock not zero in pass-through");
    a_dual_ttl: assert property ( // R3
        !pass_dec && clk_sel_in == CLKSEL_DUAL_COMP_TTL
        |=> dual_ttl_en_out && dual_ttl_comp_out)
        else $error("dual leg select wrong");
    a_sync_pass: assert property (pass_dec |=> hsync_output_pin // R5
        == $past(hsync_n_in) && vsync_output_pin == $past(vsync_n_in))
        else $error("sync inverted in pass-through");
    a_green_sync: assert property (!hsync_n_in |=> !green_sync_n_out) // R6
        else $error("green sync missing");
    a_flag_low: assert property (mux_ctrl_we_in // R7
        && mux_ctrl_in == MUX_PASSTHRU_CODE |=> !external_mux_flag)
        else $error("mux flag not low");
    a_flag_high: assert property (!mux_ctrl_we_in && gen_ctrl_we_in // R8
        && gen_ctrl_in[GCTL_MUXFLAG_BIT] && pass_dec |=> external_mux_flag)
        else $error("mux flag not high");
    a_mode_update: assert property ( // R14
        passthru_out == ($past(mux_reg) == MUX_PASSTHRU_CODE))
        else $error("mode decode out of step");
    a_read_start: assert property ($fell(read_n_in) && host_state // R12
        == VPC_HOST_IDLE |=> host_read_pulse_out ##1 !host_read_pulse_out)
        else $error("read not started");
    a_endian: assert property (big_endian_in |=> pixel_out[7:0] // R10
        == $past(pixel_in[PIX_W-1 -: 8]))
        else $error("endian swap wrong");

    c_passthru: cover property ($rose(passthru_out));
    c_flag_high: cover property (passthru_out && $rose(external_mux_flag));
    c_read: cover property (host_read_pulse_out);
    c_write: cover property (host_write_pulse_out);
endmodule
`default_nettype wire

// ### design/vpc_pkg.sv
// Package for the video pass-through pin control block.
// Assumes one 20 MHz clock domain; all settings arrive as plain ports.
package vpc_pkg;
    localparam logic [7:0] MUX_PASSTHRU_CODE = 8'h2D;
    localparam int GCTL_MUXFLAG_BIT = 7;
    localparam int PIX_WIDTH = 32;
    localparam int CLKSEL_WIDTH = 4;
    localparam logic [3:0] CLKSEL_DEFAULT = 4'h0;
    localparam logic [3:0] CLKSEL_DUAL_TRUE_TTL = 4'h8;
    localparam logic [3:0] CLKSEL_DUAL_COMP_TTL = 4'h9;
    localparam logic [1:0] CLKSRC_ZERO = 2'h0;
    localparam logic [1:0] CLKSRC_ONE = 2'h1;
    localparam logic [1:0] CLKSRC_TWO = 2'h2;
    localparam logic [1:0] CLKSRC_DUAL = 2'h3;
    localparam logic [7:0] MUX_RESET = 8'h00;
    localparam logic [7:0] GCTL_RESET = 8'h00;
    localparam logic [7:0] READ_IDLE = 8'h00;

    typedef enum logic [1:0] {VPC_HOST_IDLE, VPC_HOST_READ, VPC_HOST_WRITE}
        vpc_host_e;

    function automatic logic is_passthru(input logic [7:0] mux_code);
        is_passthru = (mux_code == MUX_PASSTHRU_CODE);
    endfunction
endpackage

// ### design/vpc_sync_gate.sv
// Sync true/complement gate, registered.
// Assumes sync inputs synchronous to clk_in.
`timescale 1ns/1ns
`default_nettype none
module vpc_sync_gate
    import vpc_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n,
    input wire logic sync_n_in,
    input wire logic invert_in,
    input wire logic passthru_in,
    output logic sync_out
);
    logic next_sync;

    always_comb
    begin
        // R5: pass-through ignores polarity control
        if (passthru_in)
        begin
            next_sync = sync_n_in; // R5
        end
        else
        begin
            next_sync = sync_n_in ^ invert_in; // R4
        end
    end

    always_ff @(posedge clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync_out <= 1'b1;
        end
        else
        begin
            sync_out <= next_sync;
        end
    end

    // First cycle after reset still shows the reset level
    a_sync_polarity: assert property ( // R4
        @(posedge clk_in) disable iff (!rst_n) $past(rst_n) |->
        sync_out == ($past(passthru_in) ? $past(sync_n_in)
        : $past(sync_n_in) ^ $past(invert_in)))
        else $error("sync gate output wrong");
endmodule
`default_nettype wire

// ### verif/test_vga_passthrough_pin_control.sv
// Self-checking bench for the pass-through pin control block.
// Assumes the pixel source model drives syncs, blanks and pixels.
`timescale 1ns/1ns
`default_nettype none
module test_vga_passthrough_pin_control;
    import vpc_pkg::*;
    logic clk_in, rst_n_in, mux_ctrl_we_in, gen_ctrl_we_in, hold_in;
    logic [7:0] mux_ctrl_in, gen_ctrl_in, host_data_in, read_data_in;
    logic [3:0] clk_sel_in, reg_select;
    logic hsync_invert_in, vsync_invert_in, big_endian_in;
    logic blank_n_in, alt_blank_in, hsync_n_in, vsync_n_in;
    logic read_n_in, write_n_in;
    logic [31:0] pixel_in, pixel_out;
    logic [7:0] host_data_out, host_write_data_out;
    logic [3:0] host_reg_sel_out;
    logic [1:0] clk_source_out;
    logic host_data_oe_n_out, host_read_pulse_out, host_write_pulse_out;
    logic blank_n_out, dual_ttl_comp_out, dual_ttl_en_out;
    logic hsync_output_pin, vsync_output_pin, green_sync_n_out;
    logic external_mux_flag, passthru_out;
    int failures = 0;
    int n_checks = 0;

    vpc_pin_control vpc_pin_control_inst (.clk_in, .rst_n_in, .mux_ctrl_in,
        .mux_ctrl_we_in, .gen_ctrl_in, .gen_ctrl_we_in, .clk_sel_in,
        .hsync_invert_in, .vsync_invert_in, .big_endian_in, .blank_n_in,
        .alt_blank_in, .hsync_n_in, .vsync_n_in, .pixel_in, .read_n_in,
        .write_n_in, .reg_select, .host_data_in, .read_data_in,
        .host_data_out, .host_data_oe_n_out, .host_reg_sel_out,
        .host_read_pulse_out, .host_write_pulse_out, .host_write_data_out,
        .blank_n_out, .clk_source_out, .dual_ttl_comp_out, .dual_ttl_en_out,
        .hsync_output_pin, .vsync_output_pin, .green_sync_n_out,
        .external_mux_flag, .passthru_out, .pixel_out);

    vpc_video_src vpc_video_src_inst (.clk_in, .rst_n_in, .hold_in,
        .hsync_n_out(hsync_n_in), .vsync_n_out(vsync_n_in),
        .blank_n_out(blank_n_in), .alt_blank_out(alt_blank_in),
        .pixel_out(pixel_in));

    initial
    begin
        clk_in = 1'h0;
        forever #25 clk_in = ~clk_in;
    end

    task automatic tick;
        @(posedge clk_in);
        #2;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
        input string what);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t %s", $time, what);
        end
    endtask

    task automatic close_out;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic wr_mux(input logic [7:0] code);
        mux_ctrl_in = code;
        mux_ctrl_we_in = 1'h1;
        tick;
        mux_ctrl_we_in = 1'h0;
    endtask

    task automatic wr_gen(input logic [7:0] val);
        gen_ctrl_in = val;
        gen_ctrl_we_in = 1'h1;
        tick;
        gen_ctrl_we_in = 1'h0;
    endtask

    // Inputs seen at one edge against outputs one cycle on
    task automatic check_stream(input int n, input logic pt);
        logic h, v, b, a;
        logic [31:0] p;
        repeat (n)
        begin
            h = hsync_n_in;
            v = vsync_n_in;
            b = blank_n_in;
            a = alt_blank_in;
            p = pixel_in;
            tick;
            chk(hsync_output_pin, pt ? h : h ^ hsync_invert_in, "hs");
            chk(vsync_output_pin, pt ? v : v ^ vsync_invert_in, "vs");
            chk(green_sync_n_out, h & v, "green sync");
            chk(blank_n_out, pt ? a : b, "blank");
            chk(pixel_out, big_endian_in ? {p[7:0], p[15:8], p[23:16],
                p[31:24]} : p, "pixel");
        end
    endtask

    task automatic t_normal_sync;
        for (int i = 0; i < 4; i++)
        begin
            hsync_invert_in = i[0];
            vsync_invert_in = i[1];
            big_endian_in = i[0];
            hold_in = i[1];
            tick;
            check_stream(12, 1'h0);
        end
        hold_in = 1'h0;
        $display("test normal_sync done");
    endtask

    task automatic t_clock_select;
        logic [3:0] sel [5] = '{4'h0, 4'h1, 4'h2, CLKSEL_DUAL_TRUE_TTL,
            CLKSEL_DUAL_COMP_TTL};
        for (int i = 0; i < 5; i++)
        begin
            clk_sel_in = sel[i];
            repeat (3) tick;
            chk(clk_source_out, (i < 3) ? i : 3, "clk src");
            chk(dual_ttl_en_out, i >= 3, "ttl en");
            chk(dual_ttl_comp_out, i == 4, "ttl comp");
        end
        $display("test clock_select done");
    endtask

    task automatic t_passthru;
        clk_sel_in = 4'h2;
        hsync_invert_in = 1'h1;
        vsync_invert_in = 1'h1;
        tick;
        // Arming before the code must not lift the flag
        wr_gen(8'h80);
        wr_mux(MUX_PASSTHRU_CODE);
        // Flag moves at the write edge, mode outputs one edge later
        chk(external_mux_flag, 1'h0, "flag low");
        chk(passthru_out, 1'h0, "early pt");
        tick;
        chk(passthru_out, 1'h1, "pt on");
        chk(clk_source_out, CLKSRC_ZERO, "pt clk");
        check_stream(12, 1'h1);
        wr_gen(8'h80);
        tick;
        chk(external_mux_flag, 1'h1, "flag high");
        chk(passthru_out, 1'h1, "pt kept");
        chk(clk_source_out, CLKSRC_ZERO, "clk kept");
        check_stream(4, 1'h1);
        wr_mux(MUX_PASSTHRU_CODE);
        tick;
        chk(external_mux_flag, 1'h0, "rearm");
        wr_mux(8'h00);
        repeat (2) tick;
        chk(passthru_out, 1'h0, "pt off");
        chk(clk_source_out, CLKSRC_TWO, "clk back");
        check_stream(8, 1'h0);
        $display("test passthru done");
    endtask

    task automatic t_host;
        read_n_in = 1'h0;
        reg_select = 4'hA;
        tick;
        chk(host_read_pulse_out, 1'h1, "rd pulse");
        chk(host_reg_sel_out, 4'hA, "rd sel");
        tick;
        chk(host_data_oe_n_out, 1'h0, "rd drive");
        chk(host_data_out, 8'h3C, "rd data");
        chk(host_read_pulse_out, 1'h0, "rd once");
        read_n_in = 1'h1;
        tick;
        chk(host_data_oe_n_out, 1'h1, "rd release");
        tick;
        write_n_in = 1'h0;
        reg_select = 4'h5;
        host_data_in = 8'h96;
        tick;
        tick;
        chk(host_reg_sel_out, 4'h5, "wr sel");
        write_n_in = 1'h1;
        tick;
        chk(host_write_pulse_out, 1'h1, "wr pulse");
        chk(host_write_data_out, 8'h96, "wr data");
        tick;
        chk(host_write_pulse_out, 1'h0, "wr once");
        $display("test host done");
    endtask

    initial
    begin
        {rst_n_in, mux_ctrl_we_in, gen_ctrl_we_in, hold_in} = 4'h0;
        {mux_ctrl_in, gen_ctrl_in, host_data_in} = 24'h000000;
        {clk_sel_in, reg_select} = 8'h00;
        {hsync_invert_in, vsync_invert_in, big_endian_in} = 3'h0;
        {read_n_in, write_n_in} = 2'h3;
        read_data_in = 8'h3C;
        repeat (16) @(posedge clk_in);
        #2;
        chk(external_mux_flag, 1'h1, "rst flag");
        chk(passthru_out, 1'h0, "rst pt");
        chk(host_data_oe_n_out, 1'h1, "rst oe");
        chk(hsync_output_pin, 1'h1, "rst hs");
        $display("test reset done");
        rst_n_in = 1'h1;
        repeat (3) tick;
        t_normal_sync;
        t_clock_select;
        t_passthru;
        t_host;
        close_out;
    end

    // Tests need about 130 cycles; this 20000-cycle margin only cuts a hang
    initial
    begin
        #(50 * 20000);
        failures++;
        close_out;
    end
endmodule
`default_nettype wire

// ### verif/vpc_video_src.sv
// Pixel source model: raster syncs, two blanks and pixel words.
// Assumes clk_in is the block clock; outputs move 1 ns after the rise.
`timescale 1ns/1ns
`default_nettype none
module vpc_video_src
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic hold_in,
    output logic hsync_n_out,
    output logic vsync_n_out,
    output logic blank_n_out,
    output logic alt_blank_out,
    output logic [31:0] pixel_out
);
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    // Hold stalls the raster, as a slow source would
    always_comb
    begin
        next_cnt = hold_in ? cnt : cnt + 8'h01;
    end
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            cnt <= 8'h00;
        else
            cnt <= next_cnt;
    end
    // Delay keeps edges clear of the bench sampling point
    assign #1 hsync_n_out = (cnt[1:0] != 2'h3);
    assign #1 vsync_n_out = (cnt[4:3] != 2'h3);
    assign #1 blank_n_out = (cnt[2:0] != 3'h0);
    assign #1 alt_blank_out = cnt[1] ^ cnt[4];
    assign #1 pixel_out = {cnt, ~cnt, cnt ^ 8'hA5, cnt + 8'h11};
endmodule
`default_nettype wire
